// ---- hw/pcc_pkg.sv ----
// Shared constants for the pulse counter with target compare
`default_nettype none
package pcc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned CNT_W_DEF = 32;
    localparam int unsigned HALF_W    = 16;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned ST_W      = 2;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_TARGET = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] OFS_CMP    = 8'h10;
    localparam logic [7:0] OFS_STAT   = 8'h14;
    localparam logic [7:0] OFS_MASK   = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned B_EN      = 0;
    localparam int unsigned B_CLR     = 1;
    localparam int unsigned B_START   = 2;
    localparam int unsigned B_DIR     = 3;
    localparam int unsigned B_MODE    = 4;
    localparam int unsigned B_ARM     = 0;
    localparam int unsigned B_ST_MTCH = 0;
    localparam int unsigned B_ST_RES  = 1;

    // ------------------------------------------------------------
    // Input mode codes; code 3 is illegal and counts nothing
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_QUAD  = 2'h0;
    localparam logic [1:0] MODE_PDIR  = 2'h1;
    localparam logic [1:0] MODE_PFLAG = 2'h2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RST_MODE   = 2'h0;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;

    // Quadrature step decode: returns {step, up}; A leading B is up
    function automatic logic [1:0] quad_step(input logic [1:0] prev,
                                             input logic [1:0] cur);
        logic [1:0] r;
        r = 2'h0;
        unique case ({prev, cur})
            4'h2, 4'hB, 4'hD, 4'h4: r = 2'h3;
            4'h8, 4'hE, 4'h7, 4'h1: r = 2'h2;
            default:                r = 2'h0;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// ---- hw/pcc_link_if.sv ----
// Link between the counter core, the input decoder and the compare unit
`default_nettype none
interface pcc_link_if #(parameter int unsigned CW = 32);
    logic [1:0]    mode;
    logic          dir_flag;
    logic          step;
    logic          up;
    logic          arm;
    logic          moved;
    logic [CW-1:0] count;
    logic [CW-1:0] target;
    logic          result;

    modport dec (input mode, dir_flag, output step, up);
    modport cmp (input arm, moved, count, target, output result);
endinterface
`default_nettype wire

// ---- hw/pcc_decoder.sv ----
// Input decoder: quadrature, pulse plus level, pulse plus flag
`default_nettype none
module pcc_decoder
    import pcc_pkg::*;
(
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // Encoder phases
    input  wire logic i_enc_a,
    input  wire logic i_enc_b,
    // Link to the core
    pcc_link_if.dec   lk
);
    typedef struct packed {
        logic a_prev;
        logic b_prev;
        logic step;
        logic up;
    } pcc_dec_t;

    pcc_dec_t s_r;
    pcc_dec_t s_nxt;

    // Step and direction per mode; one cycle of latency on each
    always_comb begin
        s_nxt        = s_r;
        s_nxt.a_prev = i_enc_a;
        s_nxt.b_prev = i_enc_b;
        s_nxt.step   = 1'h0;
        unique case (lk.mode)
            MODE_QUAD: begin
                {s_nxt.step, s_nxt.up} = quad_step({s_r.a_prev, s_r.b_prev},
                                                   {i_enc_a, i_enc_b});
            end
            MODE_PDIR: begin
                s_nxt.step = i_enc_a & ~s_r.a_prev;
                s_nxt.up   = ~i_enc_b;
            end
            MODE_PFLAG: begin
                s_nxt.step = i_enc_a & ~s_r.a_prev;
                s_nxt.up   = ~lk.dir_flag;
            end
            default: s_nxt.step = 1'h0;
        endcase
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lk.step = s_r.step;
    assign lk.up   = s_r.up;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_quad_up;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (lk.mode == MODE_QUAD && {s_r.a_prev, s_r.b_prev} == 2'h0 &&
         {i_enc_a, i_enc_b} == 2'h2) |=> (lk.step && lk.up);
    endproperty
    a_quad_up: assert property (p_quad_up)
        else $error("quadrature A-leads-B edge did not count up");

    property p_pdir;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (lk.mode == MODE_PDIR && i_enc_a && !s_r.a_prev) |=>
        (lk.step && lk.up == !$past(i_enc_b));
    endproperty
    a_pdir: assert property (p_pdir)
        else $error("pulse plus level mode step or direction wrong");

    property p_pflag;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (lk.mode == MODE_PFLAG && $stable(i_enc_a)) |=> !lk.step;
    endproperty
    a_pflag: assert property (p_pflag)
        else $error("pulse plus flag mode stepped without an A edge");
endmodule
`default_nettype wire

// ---- hw/pcc_compare.sv ----
// Compare unit: armed by an arm edge, latches a hit on the target
`default_nettype none
module pcc_compare
    import pcc_pkg::*;
(
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // Link to the core
    pcc_link_if.cmp   lk
);
    typedef struct packed {
        logic arm_prev;
        logic armed;
        logic result;
    } pcc_cmp_t;

    pcc_cmp_t s_r;
    pcc_cmp_t s_nxt;

    // A level on the arm bit does nothing; only its rising edge arms
    always_comb begin
        s_nxt          = s_r;
        s_nxt.arm_prev = lk.arm;
        if (lk.arm && !s_r.arm_prev) begin
            s_nxt.armed  = 1'h1;
            s_nxt.result = 1'h0;
        end
        // A hit beats the re-arm clear in the same cycle
        if (s_r.armed && lk.moved && lk.count == lk.target) begin
            s_nxt.result = 1'h1;
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lk.result = s_r.result;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_arm_edge;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (lk.arm && !s_r.arm_prev) |=> s_r.armed;
    endproperty
    a_arm_edge: assert property (p_arm_edge)
        else $error("arm edge did not arm the compare");

    property p_hit;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_r.armed && lk.moved && lk.count == lk.target) |=>
        s_r.result;
    endproperty
    a_hit: assert property (p_hit)
        else $error("compare hit not latched");

    property p_hold;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_r.result && !(lk.arm && !s_r.arm_prev)) |=> s_r.result;
    endproperty
    a_hold: assert property (p_hold)
        else $error("compare result dropped");

    c_hit: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(s_r.armed) ##[1:1000] $rose(s_r.result));
endmodule
`default_nettype wire

// ---- hw/pcc_top.sv ----
// Pulse counter with target compare and AHB-Lite register slave
//
// What this block does
// - Counting runs only while the enable flag is set and stops when it is clear.
// - A rising start flag begins counting when the enable flag is already set.
// - The match status is high while the count equals the target value and the clear flag is clear.
// - The clear flag zeroes the count and drops the match status.
// - Mode zero counts both quadrature phases at four times the pulse rate.
// - Mode one counts pulses on A with the direction from the level of B.
// - Mode two counts pulses on A only, direction from the software flag.
// - In mode two a clear flag counts up and a set flag counts down.
// - An armed compare latches its result when the count steps onto the target.
// - The count is readable as a low word and a high word of 16 bits.
// - The compare begins when its arm condition goes from off to on.
//
// The register offsets and the AHB-Lite slave port were decided locally.
`default_nettype none
module pcc_top
    import pcc_pkg::*;
#(
    parameter int unsigned CNT_W = CNT_W_DEF
)(
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    // AHB-Lite slave
    input  wire logic              i_hsel,
    input  wire logic [31:0]       i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [DATA_W-1:0] i_hwdata,
    input  wire logic              i_hready,
    output var  logic              o_hreadyout,
    output var  logic              o_hresp,
    output var  logic [DATA_W-1:0] o_hrdata,
    // Encoder inputs from the pulse feedback card
    input  wire logic              i_enc_a,
    input  wire logic              i_enc_b,
    // Status outputs
    output var  logic              o_count_match,
    output var  logic              o_cmp_result,
    output var  logic              o_irq
);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic              en;
        logic              clr;
        logic              start;
        logic              dir;
        logic [1:0]        mode;
        logic              arm;
        logic [CNT_W-1:0]  target;
        logic [CNT_W-1:0]  count;
        logic              match;
        logic              started;
        logic              start_prev;
        logic              moved;
        logic              res_prev;
        logic [ST_W-1:0]   status;
        logic [ST_W-1:0]   mask;
        logic              irq;
        logic              wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] rdata;
        logic              ready;
    } pcc_state_t;

    pcc_state_t s_r;
    pcc_state_t s_nxt;

    pcc_link_if #(.CW(CNT_W)) u_lk ();

    logic bus_take;
    logic hi_zero;
    logic run;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Only NONSEQ/SEQ with hready high start a transfer
    assign bus_take = i_hsel & i_htrans[1] & i_hready;
    assign hi_zero  = (i_haddr[31:ADDR_W] == '0);
    assign run      = s_r.en & s_r.started;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [ST_W-1:0]   w1c;
        logic [ST_W-1:0]   ev;
        logic [DATA_W-1:0] rd;
        w1c   = '0;
        ev    = '0;
        rd    = '0;
        s_nxt = s_r;

        // Zero wait states; the bus never sees an error
        s_nxt.ready   = 1'h1;
        s_nxt.wr_pend = bus_take & i_hwrite & hi_zero;
        s_nxt.wr_addr = i_haddr[ADDR_W-1:0];

        // Data phase of a write
        if (s_r.wr_pend) begin
            unique case (s_r.wr_addr)
                OFS_CTRL: begin
                    s_nxt.en    = i_hwdata[B_EN];
                    s_nxt.clr   = i_hwdata[B_CLR];
                    s_nxt.start = i_hwdata[B_START];
                    s_nxt.dir   = i_hwdata[B_DIR];
                    s_nxt.mode  = i_hwdata[B_MODE +: 2];
                end
                OFS_TARGET: s_nxt.target = i_hwdata[CNT_W-1:0];
                OFS_CMP:    s_nxt.arm    = i_hwdata[B_ARM];
                OFS_STAT:   w1c          = i_hwdata[ST_W-1:0];
                OFS_MASK:   s_nxt.mask   = i_hwdata[ST_W-1:0];
                default:    w1c          = '0;
            endcase
        end

        // Start is taken on its rising edge; dropping enable stops all
        s_nxt.start_prev = s_r.start;
        if (!s_r.en) begin
            s_nxt.started = 1'h0;
        end else if (s_r.start && !s_r.start_prev) begin
            s_nxt.started = 1'h1;
        end

        // Counter; clear overrides any step in the same cycle
        s_nxt.moved = 1'h0;
        if (s_r.clr) begin
            s_nxt.count = '0;
        end else if (run && u_lk.step) begin
            s_nxt.moved = 1'h1;
            if (u_lk.up) begin
                s_nxt.count = s_r.count + CNT_ONE;
            end else begin
                s_nxt.count = s_r.count - CNT_ONE;
            end
        end

        // Match is a level; it wraps with the count, as it is 2's complement
        s_nxt.match = ~s_r.clr & (s_nxt.count == s_nxt.target);

        // Sticky events; a new event beats a clear written with it
        s_nxt.res_prev      = u_lk.result;
        ev[B_ST_MTCH]       = s_nxt.match & ~s_r.match;
        ev[B_ST_RES]        = u_lk.result & ~s_r.res_prev;
        s_nxt.status        = (s_r.status & ~w1c) | ev;
        s_nxt.irq           = |(s_nxt.status & s_nxt.mask);

        // Read mux sees this cycle's write, so back-to-back reads are fresh
        rd[B_EN]            = s_nxt.en;
        rd[B_CLR]           = s_nxt.clr;
        rd[B_START]         = s_nxt.start;
        rd[B_DIR]           = s_nxt.dir;
        rd[B_MODE +: 2]     = s_nxt.mode;
        if (bus_take && !i_hwrite) begin
            s_nxt.rdata = RST_WORD;
            if (hi_zero) begin
                unique case (i_haddr[ADDR_W-1:0])
                    OFS_CTRL:   s_nxt.rdata = rd;
                    OFS_TARGET: s_nxt.rdata = s_nxt.target;
                    OFS_CNT_LO: s_nxt.rdata[HALF_W-1:0] =
                                    s_nxt.count[HALF_W-1:0];
                    OFS_CNT_HI: s_nxt.rdata[HALF_W-1:0] =
                                    s_nxt.count[CNT_W-1:HALF_W];
                    OFS_CMP:    s_nxt.rdata[B_ARM] = s_nxt.arm;
                    OFS_STAT:   s_nxt.rdata[ST_W-1:0] = s_nxt.status;
                    OFS_MASK:   s_nxt.rdata[ST_W-1:0] = s_nxt.mask;
                    default:    s_nxt.rdata = RST_WORD;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Submodules and link
    // ------------------------------------------------------------
    assign u_lk.mode     = s_r.mode;
    assign u_lk.dir_flag = s_r.dir;
    assign u_lk.arm      = s_r.arm;
    assign u_lk.moved    = s_r.moved;
    assign u_lk.count    = s_r.count;
    assign u_lk.target   = s_r.target;

    pcc_decoder u_dec (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_enc_a   (i_enc_a),
        .i_enc_b   (i_enc_b),
        .lk        (u_lk.dec)
    );

    pcc_compare u_cmp (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .lk        (u_lk.cmp)
    );

    // Outputs, all from flops but o_hresp, which is tied low
    assign o_hreadyout   = s_r.ready;
    assign o_hresp       = 1'h0;
    assign o_hrdata      = s_r.rdata;
    assign o_count_match = s_r.match;
    assign o_cmp_result  = u_lk.result;
    assign o_irq         = s_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_disabled;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (!s_r.en && !s_r.clr) |=> $stable(s_r.count);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("count moved while disabled");

    property p_start;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_r.en && s_r.start && !s_r.start_prev) |=> s_r.started;
    endproperty
    a_start: assert property (p_start)
        else $error("start edge with enable did not start counting");

    property p_match;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (!s_r.clr && s_nxt.count == s_nxt.target) |=> o_count_match;
    endproperty
    a_match: assert property (p_match)
        else $error("match not raised on count equal to target");

    property p_clear;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        s_r.clr |=> (s_r.count == '0 && !o_count_match);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero count and match");

    property p_flag_down;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_r.mode == MODE_PFLAG && s_r.dir && $stable(s_r.dir) &&
         $stable(s_r.mode) && run && u_lk.step && !s_r.clr) |=>
        (s_r.count == $past(s_r.count) - CNT_ONE);
    endproperty
    a_flag_down: assert property (p_flag_down)
        else $error("flag set did not count down by one");

    property p_read_lo;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (bus_take && !i_hwrite && hi_zero &&
         i_haddr[ADDR_W-1:0] == OFS_CNT_LO) |=>
        (o_hrdata == {16'h0000, $past(s_nxt.count[HALF_W-1:0])});
    endproperty
    a_read_lo: assert property (p_read_lo)
        else $error("low count word read back wrong");

    c_match: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(o_count_match));
    c_result: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(o_cmp_result));
    c_quad_down: cover property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        s_r.mode == MODE_QUAD && run && u_lk.step && !u_lk.up);
endmodule
`default_nettype wire

// ---- bench/pcc_enc_model.sv ----
// Encoder model: quadrature and pulse trains for the counter inputs
`default_nettype none
module pcc_enc_model (
    // Clock
    input  wire logic i_sys_clk,
    // Encoder phases
    output var  logic o_enc_a,
    output var  logic o_enc_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph;
    initial begin
        ph = 2'h0;
        o_enc_a = 1'b0;
        o_enc_b = 1'b0;
    end
    // Two clocks a level, so the decoder always sees it settled
    task automatic hold2();
        repeat (2) @(posedge i_sys_clk);
    endtask
    // Gray walk 00,10,11,01: walking up means A leads B
    task automatic quad(input int n, input bit up);
        for (int k = 0; k < n; k++) begin
            ph = up ? ph + 2'h1 : ph - 2'h1;
            o_enc_a <= ph[0] ^ ph[1];
            o_enc_b <= ph[1];
            hold2();
        end
        repeat (3) @(posedge i_sys_clk);
    endtask
    // A drops first so the first pulse is never lost; B set ahead of A
    task automatic pulse(input int n, input bit b);
        o_enc_a <= 1'b0;
        o_enc_b <= b;
        hold2();
        for (int k = 0; k < n; k++) begin
            o_enc_a <= 1'b1;
            hold2();
            o_enc_a <= 1'b0;
            hold2();
        end
        ph = b ? 2'h3 : 2'h0;
        repeat (3) @(posedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- bench/pcc_top_tb.sv ----
// Self-checking bench for the pulse counter with target compare
`default_nettype none
module pcc_top_tb
    import pcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hready, hresp, enc_a, enc_b, match, result, irq;
    int          mismatches = 0;
    int          check_count = 0;
    localparam logic [3:0] EN = 4'h1, CLR = 4'h2, ST = 4'h4, DN = 4'h8;

    always #4 clk = ~clk;

    pcc_top pcc_top_i (.i_sys_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_enc_a(enc_a), .i_enc_b(enc_b), .o_count_match(match),
        .o_cmp_result(result), .o_irq(irq));
    pcc_enc_model pcc_enc_model_i (.i_sys_clk(clk), .o_enc_a(enc_a),
        .o_enc_b(enc_b));

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Address held until hready seen high, then data phase likewise
    task automatic ahb(input bit wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0000_0000, x);
        chk(nm, x, e);
    endtask
    task automatic ctl(input logic [1:0] m, input logic [3:0] b);
        wr(OFS_CTRL, {26'h000_0000, m, b});
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("hresp", {31'h0, hresp}, 32'h0);
        rdc("ctrl", OFS_CTRL, RST_WORD);
        rdc("count_lo", OFS_CNT_LO, RST_WORD);
        wr(8'h40, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h40, 32'h0000_0000);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_count();
        ctl(MODE_QUAD, EN);
        pcc_enc_model_i.quad(4, 1'b1);
        rdc("no start", OFS_CNT_LO, 32'h0);
        ctl(MODE_QUAD, EN | ST);
        pcc_enc_model_i.quad(8, 1'b1);
        rdc("quad up", OFS_CNT_LO, 32'h8);
        pcc_enc_model_i.quad(3, 1'b0);
        rdc("quad down", OFS_CNT_LO, 32'h5);
        ctl(MODE_QUAD, 4'h0);
        pcc_enc_model_i.quad(4, 1'b1);
        rdc("disabled", OFS_CNT_LO, 32'h5);
        ctl(MODE_QUAD, CLR);
        rdc("cleared", OFS_CNT_LO, 32'h0);
        $display("test count done");
    endtask
    task automatic t_modes();
        ctl(MODE_PDIR, EN);
        ctl(MODE_PDIR, EN | ST);
        pcc_enc_model_i.pulse(5, 1'b0);
        pcc_enc_model_i.pulse(2, 1'b1);
        rdc("pulse dir", OFS_CNT_LO, 32'h3);
        ctl(MODE_PFLAG, EN | ST);
        pcc_enc_model_i.pulse(4, 1'b1);
        rdc("flag up", OFS_CNT_LO, 32'h7);
        ctl(MODE_PFLAG, EN | ST | DN);
        pcc_enc_model_i.pulse(3, 1'b0);
        rdc("flag down", OFS_CNT_LO, 32'h4);
        // Mode code three is left unused and must count nothing
        ctl(2'h3, EN | ST | DN);
        pcc_enc_model_i.pulse(2, 1'b0);
        rdc("mode three", OFS_CNT_LO, 32'h4);
        ctl(MODE_PFLAG, CLR);
        ctl(MODE_PFLAG, EN | DN);
        ctl(MODE_PFLAG, EN | ST | DN);
        pcc_enc_model_i.pulse(1, 1'b0);
        rdc("low word", OFS_CNT_LO, 32'h0000_FFFF);
        rdc("high word", OFS_CNT_HI, 32'h0000_FFFF);
        $display("test modes done");
    endtask
    task automatic t_compare();
        ctl(MODE_QUAD, CLR);
        wr(OFS_TARGET, 32'h0000_0003);
        wr(OFS_MASK, 32'h0000_0003);
        wr(OFS_STAT, 32'h0000_0003);
        ctl(MODE_QUAD, EN);
        ctl(MODE_QUAD, EN | ST);
        // Arm by an off-to-on edge, never by a held level
        wr(OFS_CMP, 32'h0);
        wr(OFS_CMP, 32'h1);
        pcc_enc_model_i.quad(2, 1'b1);
        chk("below", {31'h0, result}, 32'h0);
        pcc_enc_model_i.quad(1, 1'b1);
        chk("match", {31'h0, match}, 32'h1);
        chk("hit up", {31'h0, result}, 32'h1);
        chk("irq on", {31'h0, irq}, 32'h1);
        rdc("status", OFS_STAT, 32'h3);
        pcc_enc_model_i.quad(1, 1'b1);
        chk("match off", {31'h0, match}, 32'h0);
        chk("sticky", {31'h0, result}, 32'h1);
        wr(OFS_CMP, 32'h0);
        wr(OFS_CMP, 32'h1);
        settle();
        chk("rearm", {31'h0, result}, 32'h0);
        pcc_enc_model_i.quad(1, 1'b0);
        chk("hit down", {31'h0, result}, 32'h1);
        wr(OFS_MASK, 32'h0);
        settle();
        chk("masked", {31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h3);
        wr(OFS_STAT, 32'h3);
        rdc("w1c", OFS_STAT, 32'h0);
        settle();
        chk("irq off", {31'h0, irq}, 32'h0);
        $display("test compare done");
    endtask
    // Reset in mid-run: outputs drop at once, registers come back zero
    task automatic t_midrst();
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        chk("rst ready", {31'h0, hready}, 32'h0);
        chk("rst match", {31'h0, match}, 32'h0);
        chk("rst result", {31'h0, result}, 32'h0);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdc("rst target", OFS_TARGET, RST_WORD);
        rdc("rst count", OFS_CNT_LO, RST_WORD);
        $display("test mid reset done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence: ten clocks of reset, two spare edges, then tests
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_count();
        t_modes();
        t_compare();
        t_midrst();
        wrap_up();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
